/* File: rtl/dmd_map.vh */
// Constants for the dual-modulus divider control block
//
// Notes on behaviour
// - Load, count down, count up, reload forever
// - Modulus high while down, low while up
// - Negative modulus line complements the positive
// - One compare pulse per reload event
// - Compare pulse retimed to prescaler edge
// - Division: down times low, plus up times high
// - Twelve-bit counter, load range 3 to 4095
// - Up limit eight bits, zero means 256
// - Overflow forces last down count high ratio
// - Gain eight, shift two, ratio four bits
// - Compensation scales with accumulator value
// - Speed-up boosts by two to shift plus one
// - Speed-up integrator compensation times ratio
// - Integrator pumps only during speed-up
// - Compensation gate has fixed clock-timed width
// - Pump up/down last as long as error
// - Speed-up follows the load strobe only
// - Fraction modulus five or eight cycles
// - Accumulator adds numerator, overflows on reaching modulus
`ifndef DMD_MAP_VH
`define DMD_MAP_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define DMD_CNT_W        12
`define DMD_UPL_W        8
`define DMD_GAIN_W       8
`define DMD_SHIFT_W      2
`define DMD_RATIO_W      4
`define DMD_ACC_W        3

// ----------------------------------------------------------------
// Limits and moduli
// ----------------------------------------------------------------
`define DMD_N1_MIN       12'h003
`define DMD_UPL_ZERO_VAL 9'h100
`define DMD_MOD_FIVE     4'h5
`define DMD_MOD_EIGHT    4'h8

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DMD_CLK_MHZ      125
`define DMD_COMP_GATE_NS 200
`define DMD_COMP_GATE_CYC ((`DMD_COMP_GATE_NS * `DMD_CLK_MHZ + 999) / 1000)

`endif

/* File: rtl/dmd_divider.v */
// Dual-modulus programmable divider with fractional insertion and pump scaling
`timescale 1ns/1ps
`include "dmd_map.vh"

module dmd_divider
#(
  parameter CNT_W      = `DMD_CNT_W,
  parameter GATE_CYC   = `DMD_COMP_GATE_CYC
)
(
  input  wire             CLK,
  input  wire             RESETN,
  input  wire             PRESCALER_CLK_IN,
  input  wire             SYNTH_LOAD_STROBE,
  input  wire             REF_PULSE,
  input  wire [CNT_W-1:0] DOWN_COUNT_LOAD,
  input  wire [7:0]       UP_COUNT_LIMIT,
  input  wire             FRAC_MODE,
  input  wire             FRAC_MODULO_SEL,
  input  wire [2:0]       FRAC_NUMERATOR,
  input  wire [7:0]       PUMP_GAIN_CODE,
  input  wire [1:0]       SPEEDUP_SHIFT,
  input  wire [3:0]       INTEG_RATIO,
  output reg              MODULUS_CTRL_POS,
  output reg              MODULUS_CTRL_NEG,
  output reg              COMPARE_PULSE,
  output reg  [2:0]       FRAC_PHASE_SUM,
  output reg              COMP_GATE_PULSE,
  output reg              PUMP_UP,
  output reg              PUMP_DOWN,
  output reg              SPEEDUP_ACTIVE,
  output reg  [11:0]      PROP_PUMP_OUT,
  output reg  [15:0]      INTEG_PUMP_OUT,
  output reg  [6:0]       COMP_PUMP_OUT,
  output reg  [10:0]      INTEG_COMP_OUT
);

  localparam [1:0] ST_DOWN = 2'b01;
  localparam [1:0] ST_UP   = 2'b10;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Multiplies a code by 2^(shift+1) when speed-up is active
  function [11:0] boost;
    input [7:0] val;
    input       en;
    input [1:0] shift;
    begin
      if (en)
        boost = {4'h0, val} << ({1'b0, shift} + 3'h1);
      else
        boost = {4'h0, val};
    end
  endfunction

  // Three-stage synchronisers; a level is accepted only when bits 1 and 2 agree
  function agree;
    input a;
    input b;
    begin
      agree = (a == b);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0] pclk_sync_reg;
  reg       pclk_lvl_reg;
  reg [2:0] strb_sync_reg;
  reg       strb_lvl_reg;
  wire      pclk_edge;

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      pclk_sync_reg <= 3'h0;
      pclk_lvl_reg  <= 1'b0;
      strb_sync_reg <= 3'h0;
      strb_lvl_reg  <= 1'b0;
    end
    else
    begin
      pclk_sync_reg <= {pclk_sync_reg[1:0], PRESCALER_CLK_IN};
      strb_sync_reg <= {strb_sync_reg[1:0], SYNTH_LOAD_STROBE};
      if (agree(pclk_sync_reg[1], pclk_sync_reg[2]))
        pclk_lvl_reg <= pclk_sync_reg[2];
      if (agree(strb_sync_reg[1], strb_sync_reg[2]))
        strb_lvl_reg <= strb_sync_reg[2];
    end
  end

  // Counter advances on each accepted rising edge of the prescaler output
  assign pclk_edge = pclk_sync_reg[2] & ~pclk_lvl_reg & pclk_sync_reg[1];

  // ----------------------------------------------------------------
  // Parameter hold, captured while the load strobe stands
  // ----------------------------------------------------------------
  reg [CNT_W-1:0] n1_reg;
  reg [7:0]       n2_reg;
  reg [2:0]       nf_reg;
  reg [7:0]       gain_reg;
  reg [1:0]       shift_reg;
  reg [3:0]       ratio_reg;
  wire [CNT_W-1:0] n1_min;

  assign n1_min = `DMD_N1_MIN;

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      n1_reg    <= `DMD_N1_MIN;
      n2_reg    <= 8'h01;
      nf_reg    <= 3'h0;
      gain_reg  <= 8'h00;
      shift_reg <= 2'h0;
      ratio_reg <= 4'h0;
    end
    else if (strb_lvl_reg)
    begin
      // Loads below the floor would leave no time to sequence
      n1_reg    <= (DOWN_COUNT_LOAD < n1_min) ? n1_min : DOWN_COUNT_LOAD;
      n2_reg    <= UP_COUNT_LIMIT;
      nf_reg    <= FRAC_NUMERATOR;
      gain_reg  <= PUMP_GAIN_CODE;
      shift_reg <= SPEEDUP_SHIFT;
      ratio_reg <= INTEG_RATIO;
    end
  end

  // ----------------------------------------------------------------
  // Up/down counter and modulus control
  // ----------------------------------------------------------------
  reg [1:0]       state_reg;
  reg [1:0]       state_next;
  reg [CNT_W-1:0] cnt_reg;
  reg [CNT_W-1:0] cnt_next;
  reg             reload;
  reg             mod_next;
  reg             ovf_pend_reg;
  wire [8:0]      up_lim;

  assign up_lim = (n2_reg == 8'h00) ? `DMD_UPL_ZERO_VAL : {1'b0, n2_reg};

  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    reload     = 1'b0;
    if (pclk_edge)
    begin
      case (state_reg)
        ST_DOWN:
        begin
          if (cnt_reg <= {{(CNT_W-1){1'b0}}, 1'b1})
          begin
            state_next = ST_UP;
            cnt_next   = {CNT_W{1'b0}};
          end
          else
            cnt_next = cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        ST_UP:
        begin
          if ({{(CNT_W-9){1'b0}}, up_lim} <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1})
          begin
            state_next = ST_DOWN;
            cnt_next   = n1_reg;
            reload     = 1'b1;
          end
          else
            cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        default:
        begin
          state_next = ST_DOWN;
          cnt_next   = n1_reg;
          reload     = 1'b1;
        end
      endcase
    end
    // Low ratio while counting down, high while counting up
    mod_next = (state_next == ST_DOWN);
    // Last down count borrows the high ratio after an overflow
    if (state_next == ST_DOWN && cnt_next == {{(CNT_W-1){1'b0}}, 1'b1} && ovf_pend_reg && FRAC_MODE)
      mod_next = 1'b0;
  end

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg        <= ST_DOWN;
      cnt_reg          <= `DMD_N1_MIN;
      MODULUS_CTRL_POS <= 1'b1;
      MODULUS_CTRL_NEG <= 1'b0;
      COMPARE_PULSE    <= 1'b0;
    end
    else
    begin
      state_reg        <= state_next;
      cnt_reg          <= cnt_next;
      // Registered a few system clocks after the prescaler edge
      MODULUS_CTRL_POS <= mod_next;
      MODULUS_CTRL_NEG <= ~mod_next;
      // One system-clock pulse tied to the edge that caused the reload
      COMPARE_PULSE    <= reload;
    end
  end

  // ----------------------------------------------------------------
  // Fractional accumulator, stepped once per comparison cycle
  // ----------------------------------------------------------------
  reg [2:0] acc_reg;
  reg [2:0] acc_next;
  reg       ovf_next;
  reg [3:0] sum;
  wire [3:0] modulus;

  assign modulus = FRAC_MODULO_SEL ? `DMD_MOD_EIGHT : `DMD_MOD_FIVE;

  always @*
  begin
    sum      = {1'b0, acc_reg} + {1'b0, nf_reg};
    ovf_next = 1'b0;
    if (sum >= modulus)
    begin
      sum      = sum - modulus;
      ovf_next = 1'b1;
    end
    acc_next = sum[2:0];
    // Zero numerator clears the accumulator; coarse eighths drop low bits
    if (nf_reg == 3'h0)
      acc_next = 3'h0;
    else if (FRAC_MODULO_SEL && nf_reg[1:0] == 2'b00)
      acc_next = {sum[2], 2'b00};
    else if (FRAC_MODULO_SEL && nf_reg[0] == 1'b0)
      acc_next = {sum[2:1], 1'b0};
  end

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      acc_reg        <= 3'h0;
      ovf_pend_reg   <= 1'b0;
      FRAC_PHASE_SUM <= 3'h0;
    end
    else if (reload && FRAC_MODE)
    begin
      acc_reg        <= acc_next;
      ovf_pend_reg   <= ovf_next;
      FRAC_PHASE_SUM <= acc_next;
    end
    else if (!FRAC_MODE)
    begin
      acc_reg        <= 3'h0;
      ovf_pend_reg   <= 1'b0;
      FRAC_PHASE_SUM <= 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // Compensation gate, fixed width from the system clock
  // ----------------------------------------------------------------
  reg [15:0] gate_cnt_reg;

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      gate_cnt_reg    <= 16'h0000;
      COMP_GATE_PULSE <= 1'b0;
    end
    else if (COMPARE_PULSE && FRAC_MODE && FRAC_PHASE_SUM != 3'h0)
    begin
      gate_cnt_reg    <= GATE_CYC[15:0] - 16'h0001;
      COMP_GATE_PULSE <= 1'b1;
    end
    else if (gate_cnt_reg != 16'h0000)
      gate_cnt_reg <= gate_cnt_reg - 16'h0001;
    else
      COMP_GATE_PULSE <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Phase detector: error pulses last as long as the phase gap
  // ----------------------------------------------------------------
  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      PUMP_UP   <= 1'b0;
      PUMP_DOWN <= 1'b0;
    end
    else
    begin
      // The lagging edge clears the leading pump without raising its own, so both are never high together
      PUMP_UP   <= (PUMP_UP | REF_PULSE) & ~(PUMP_DOWN | COMPARE_PULSE);
      PUMP_DOWN <= (PUMP_DOWN | COMPARE_PULSE) & ~(PUMP_UP | REF_PULSE);
    end
  end

  // ----------------------------------------------------------------
  // Pump scaling codes
  // ----------------------------------------------------------------
  wire [11:0] prop_next = boost(gain_reg, strb_lvl_reg, shift_reg);
  wire [11:0] comp_next = boost({5'h00, FRAC_PHASE_SUM}, strb_lvl_reg, shift_reg);

  always @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      SPEEDUP_ACTIVE <= 1'b0;
      PROP_PUMP_OUT  <= 12'h000;
      INTEG_PUMP_OUT <= 16'h0000;
      COMP_PUMP_OUT  <= 7'h00;
      INTEG_COMP_OUT <= 11'h000;
    end
    else
    begin
      // Speed-up lasts exactly as long as the load strobe
      SPEEDUP_ACTIVE <= strb_lvl_reg;
      PROP_PUMP_OUT  <= prop_next;
      COMP_PUMP_OUT  <= FRAC_MODE ? comp_next[6:0] : 7'h00;
      INTEG_PUMP_OUT <= strb_lvl_reg ? {4'h0, prop_next} * {12'h000, ratio_reg} : 16'h0000;
      INTEG_COMP_OUT <= (strb_lvl_reg && FRAC_MODE) ? comp_next[6:0] * ratio_reg : 11'h000;
    end
  end

endmodule // dmd_divider

/* File: tb/dmd_prescaler_model.sv */
// Behavioural two-modulus prescaler feeding the divider
`timescale 1ns/1ps
module dmd_prescaler_model
#(
  parameter LO = 8
)
(
  input  wire CLK,
  input  wire RESETN,
  input  wire MOD_POS,
  output reg  CLK_OUT
);
  integer cnt_reg;
  // Ratio taken at each output edge; high 3 cycles (low ratio) or 4 (high ratio) so the pin sync accepts it
  always @(negedge CLK or negedge RESETN)
    if (!RESETN)
    begin
      cnt_reg <= 0;
      CLK_OUT <= 1'b0;
    end
    else if (cnt_reg == 0)
    begin
      cnt_reg <= MOD_POS ? LO - 1 : LO;
      CLK_OUT <= 1'b1;
    end
    else
    begin
      cnt_reg <= cnt_reg - 1;
      CLK_OUT <= (cnt_reg > LO - 3);
    end
endmodule // dmd_prescaler_model

/* File: tb/dmd_divider_chk.sv */
// Concurrent checks on the divider control ports
`timescale 1ns/1ps
module dmd_divider_chk
#(
  parameter GATE_CYC = 25
)
(
  input wire        CLK,
  input wire        RESETN,
  input wire        PRESCALER_CLK_IN,
  input wire        FRAC_MODE,
  input wire [2:0]  FRAC_PHASE_SUM,
  input wire        MODULUS_CTRL_POS,
  input wire        MODULUS_CTRL_NEG,
  input wire        COMPARE_PULSE,
  input wire        COMP_GATE_PULSE,
  input wire        PUMP_UP,
  input wire        PUMP_DOWN,
  input wire        SPEEDUP_ACTIVE,
  input wire [15:0] INTEG_PUMP_OUT,
  input wire [6:0]  COMP_PUMP_OUT,
  input wire [10:0] INTEG_COMP_OUT
);
  logic [15:0] gate_cnt_reg;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESETN);
  // Counts gate high cycles so the width check needs no long repetition
  always @(posedge CLK or negedge RESETN)
    if (!RESETN)
      gate_cnt_reg <= 16'h0000;
    else
      gate_cnt_reg <= COMP_GATE_PULSE ? gate_cnt_reg + 16'h0001 : 16'h0000;
  a_mod_pair: assert property (MODULUS_CTRL_NEG == !MODULUS_CTRL_POS)
    else $error("Modulus pair not complementary");
  a_pulse_single: assert property (COMPARE_PULSE |=> !COMPARE_PULSE)
    else $error("Compare pulse longer than one cycle");
  a_reload_pulse: assert property ($rose(MODULUS_CTRL_POS) |-> ##[0:1] COMPARE_PULSE)
    else $error("Reload without compare pulse");
  a_pos_timing: assert property ($changed(MODULUS_CTRL_POS) |-> $past(PRESCALER_CLK_IN, 3)
    || $past(PRESCALER_CLK_IN, 4) || $past(PRESCALER_CLK_IN, 5))
    else $error("Modulus moved without prescaler edge");
  a_integ_off: assert property (!SPEEDUP_ACTIVE && !$past(SPEEDUP_ACTIVE)
    |-> INTEG_PUMP_OUT == 16'h0000 && INTEG_COMP_OUT == 11'h000)
    else $error("Integrator pump on outside speed-up");
  a_comp_off: assert property (!FRAC_MODE && !$past(FRAC_MODE) |-> COMP_PUMP_OUT == 7'h00)
    else $error("Compensation current outside fractional mode");
  a_gate_width: assert property ($fell(COMP_GATE_PULSE) |-> gate_cnt_reg == GATE_CYC)
    else $error("Compensation gate width wrong");
  a_pump_clear: assert property ($fell(PUMP_UP) |-> $past(COMPARE_PULSE))
    else $error("Pump up ended without compare pulse");
  a_comp_track: assert property ($past(FRAC_MODE) && !SPEEDUP_ACTIVE
    |-> COMP_PUMP_OUT == {4'h0, $past(FRAC_PHASE_SUM)})
    else $error("Compensation code not tracking accumulator");
endmodule // dmd_divider_chk
bind dmd_divider dmd_divider_chk #(.GATE_CYC(GATE_CYC)) u_chk (.CLK(CLK), .RESETN(RESETN),
  .PRESCALER_CLK_IN(PRESCALER_CLK_IN), .FRAC_MODE(FRAC_MODE), .MODULUS_CTRL_POS(MODULUS_CTRL_POS),
  .FRAC_PHASE_SUM(FRAC_PHASE_SUM),
  .MODULUS_CTRL_NEG(MODULUS_CTRL_NEG), .COMPARE_PULSE(COMPARE_PULSE), .COMP_GATE_PULSE(COMP_GATE_PULSE),
  .PUMP_UP(PUMP_UP), .PUMP_DOWN(PUMP_DOWN), .SPEEDUP_ACTIVE(SPEEDUP_ACTIVE),
  .INTEG_PUMP_OUT(INTEG_PUMP_OUT), .COMP_PUMP_OUT(COMP_PUMP_OUT), .INTEG_COMP_OUT(INTEG_COMP_OUT));

/* File: tb/dmd_divider_bench.sv */
// Self-checking bench for the divider control block
`timescale 1ns/1ps
module dmd_divider_bench;
  typedef struct {integer n; integer t; integer h;} cnote_t;
  typedef struct {logic [11:0] p; logic [15:0] i;} pnote_t;
  cnote_t      cq[$];
  pnote_t      pq[$];
  integer      seed = 74592;
  integer      error_cnt = 0;
  integer      compares = 0;
  integer      cyc = 0;
  integer      wt = 0;
  integer      wh = 0;
  integer      ph = -1;
  integer      a;
  integer      b;
  logic        pin_d = 1'b0;
  logic        s1 = 1'b0;
  logic        s2 = 1'b0;
  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        SYNTH_LOAD_STROBE = 1'b0;
  logic        REF_PULSE = 1'b0;
  logic        FRAC_MODE = 1'b0;
  logic        FRAC_MODULO_SEL = 1'b0;
  logic [11:0] DOWN_COUNT_LOAD = 12'h003;
  logic [7:0]  UP_COUNT_LIMIT = 8'h01;
  logic [2:0]  FRAC_NUMERATOR = 3'h0;
  logic [7:0]  PUMP_GAIN_CODE = 8'h00;
  logic [1:0]  SPEEDUP_SHIFT = 2'h0;
  logic [3:0]  INTEG_RATIO = 4'h0;
  wire         PRESCALER_CLK_IN;
  wire         MODULUS_CTRL_POS, MODULUS_CTRL_NEG, COMPARE_PULSE, COMP_GATE_PULSE;
  wire         PUMP_UP, PUMP_DOWN, SPEEDUP_ACTIVE;
  wire [2:0]   FRAC_PHASE_SUM;
  wire [11:0]  PROP_PUMP_OUT;
  wire [15:0]  INTEG_PUMP_OUT;
  wire [6:0]   COMP_PUMP_OUT;
  wire [10:0]  INTEG_COMP_OUT;

  always #4 CLK = ~CLK;
  // Short gate keeps the gate inside one comparison cycle
  dmd_divider #(.GATE_CYC(2)) DUT
  (
    .CLK               (CLK),
    .RESETN            (RESETN),
    .PRESCALER_CLK_IN  (PRESCALER_CLK_IN),
    .SYNTH_LOAD_STROBE (SYNTH_LOAD_STROBE),
    .REF_PULSE         (REF_PULSE),
    .DOWN_COUNT_LOAD   (DOWN_COUNT_LOAD),
    .UP_COUNT_LIMIT    (UP_COUNT_LIMIT),
    .FRAC_MODE         (FRAC_MODE),
    .FRAC_MODULO_SEL   (FRAC_MODULO_SEL),
    .FRAC_NUMERATOR    (FRAC_NUMERATOR),
    .PUMP_GAIN_CODE    (PUMP_GAIN_CODE),
    .SPEEDUP_SHIFT     (SPEEDUP_SHIFT),
    .INTEG_RATIO       (INTEG_RATIO),
    .MODULUS_CTRL_POS  (MODULUS_CTRL_POS),
    .MODULUS_CTRL_NEG  (MODULUS_CTRL_NEG),
    .COMPARE_PULSE     (COMPARE_PULSE),
    .FRAC_PHASE_SUM    (FRAC_PHASE_SUM),
    .COMP_GATE_PULSE   (COMP_GATE_PULSE),
    .PUMP_UP           (PUMP_UP),
    .PUMP_DOWN         (PUMP_DOWN),
    .SPEEDUP_ACTIVE    (SPEEDUP_ACTIVE),
    .PROP_PUMP_OUT     (PROP_PUMP_OUT),
    .INTEG_PUMP_OUT    (INTEG_PUMP_OUT),
    .COMP_PUMP_OUT     (COMP_PUMP_OUT),
    .INTEG_COMP_OUT    (INTEG_COMP_OUT)
  );
  dmd_prescaler_model PS (.CLK(CLK), .RESETN(RESETN), .MOD_POS(MODULUS_CTRL_POS), .CLK_OUT(PRESCALER_CLK_IN));

  task chk(input integer got, input integer exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("Error %0t: count %0d, expected %0d", $time, got, exp);
    end
  endtask

  task chkp(input logic [15:0] got, input logic [15:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("Error %0t: pump %h, expected %h", $time, got, exp);
    end
  endtask

  task results;
    $display("Counts: %0d mismatches, %0d compares", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task wait_pulse;
    integer k;
    k = 0;
    while (COMPARE_PULSE !== 1'b1 && k < 5000)
    begin
      @(negedge CLK);
      k = k + 1;
    end
    if (k == 5000)
    begin
      error_cnt = error_cnt + 1;
      $display("Error %0t: no compare pulse", $time);
      results;
    end
    @(negedge CLK);
  endtask

  // Parameters are captured while the strobe is high, so speed-up spans it
  task load(input [11:0] n1, input [7:0] n2, input [2:0] nf);
    pnote_t p;
    PUMP_GAIN_CODE = 8'($random(seed));
    SPEEDUP_SHIFT = 2'($random(seed));
    INTEG_RATIO = 4'($random(seed));
    DOWN_COUNT_LOAD = n1;
    UP_COUNT_LIMIT = n2;
    FRAC_NUMERATOR = nf;
    p.p = {4'h0, PUMP_GAIN_CODE} << (SPEEDUP_SHIFT + 1);
    p.i = {4'h0, p.p} * INTEG_RATIO;
    pq.push_back(p);
    pq.push_back('{{4'h0, PUMP_GAIN_CODE}, 16'h0000});
    repeat (2) @(negedge CLK);
    SYNTH_LOAD_STROBE = 1'b1;
    repeat (12) @(negedge CLK);
    SYNTH_LOAD_STROBE = 1'b0;
    repeat (3) wait_pulse;
  endtask

  task cycles(input integer n, input integer t, input integer h);
    cq.push_back('{n, t, h});
    repeat (n) wait_pulse;
  endtask

  // Edges counted per window; modulus sampled before the divider reacts
  always @(negedge CLK)
  begin
    if (PRESCALER_CLK_IN && !pin_d)
    begin
      wt = wt + 1;
      wh = wh + MODULUS_CTRL_POS;
    end
    pin_d = PRESCALER_CLK_IN;
    if (COMPARE_PULSE === 1'b1)
    begin
      // Accumulator steps are only predictable once a load has fully settled
      if (FRAC_MODE && !SYNTH_LOAD_STROBE && !SPEEDUP_ACTIVE)
      begin
        if (ph >= 0)
          chk(FRAC_PHASE_SUM, (FRAC_NUMERATOR == 3'h0) ? 0 : (ph + FRAC_NUMERATOR) % (FRAC_MODULO_SEL ? 8 : 5));
        ph = FRAC_PHASE_SUM;
      end
      else
        ph = -1;
      if (cq.size() > 0)
        cyc = cyc + 1;
      if (cq.size() > 0 && cyc == cq[0].n)
      begin
        chk(wt, cq[0].t);
        chk(wh, cq[0].h);
        void'(cq.pop_front());
        cyc = 0;
      end
      if (cyc == 0)
      begin
        wt = 0;
        wh = 0;
      end
    end
    if (s1 !== s2 && pq.size() > 0)
    begin
      chkp({4'h0, PROP_PUMP_OUT}, {4'h0, pq[0].p});
      chkp(INTEG_PUMP_OUT, pq[0].i);
      void'(pq.pop_front());
    end
    s2 = s1;
    s1 = SPEEDUP_ACTIVE;
  end

  always
  begin
    repeat (97) @(negedge CLK);
    REF_PULSE = 1'b1;
    @(negedge CLK);
    REF_PULSE = 1'b0;
  end

  initial
  begin
    repeat (20) @(negedge CLK);
    RESETN = 1'b1;
    repeat (3)
    begin
      a = 3 + {$random(seed)} % 8;
      b = 1 + {$random(seed)} % 8;
      load(a[11:0], b[7:0], 3'h0);
      cycles(2, 2 * (a + b), 2 * a);
    end
    load(12'h001, 8'h02, 3'h0);
    cycles(1, 5, 3);
    load(12'h003, 8'h00, 3'h0);
    cycles(1, 259, 3);
    // Up count of 8: limit at the low ratio of 8, load of 4
    load(12'h004, 8'h08, 3'h0);
    cycles(1, 12, 4);
    FRAC_MODE = 1'b1;
    load(12'h004, 8'h02, 3'h2);
    cycles(5, 30, 18);
    FRAC_MODULO_SEL = 1'b1;
    load(12'h004, 8'h02, 3'h3);
    cycles(8, 48, 29);
    FRAC_MODE = 1'b0;
    FRAC_MODULO_SEL = 1'b0;
    load(12'h005, 8'h03, 3'h0);
    cycles(1, 8, 5);
    RESETN = 1'b0;
    @(negedge CLK);
    chkp({15'h0000, MODULUS_CTRL_POS}, 16'h0001);
    results;
  end
endmodule // dmd_divider_bench
